// ### hfd_pkg.sv
// Purpose: constants for the hardware function decoder
// Assumes: ref_clk at 200 MHz (5 ns period)
// Notes: register offsets are byte addresses on a 32-bit APB
package hfd_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned DEC_LONG_NS = 200;
    localparam int unsigned DEC_SHORT_NS = 100;
    localparam int unsigned HALT_US = 15;
    localparam int unsigned CLEAR_US = 2;
    localparam int unsigned STEP_NS = 100;
    localparam int unsigned DEC_LONG_CYC = DEC_LONG_NS * 1000 / CLK_PERIOD_PS;
    localparam int unsigned DEC_SHORT_CYC = DEC_SHORT_NS * 1000 / CLK_PERIOD_PS;
    localparam int unsigned HALT_CYC = HALT_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned CLEAR_CYC = CLEAR_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned STEP_CYC = STEP_NS * 1000 / CLK_PERIOD_PS;

    localparam logic [15:0] FC_LOAD_BUF = 16'h0018;
    localparam logic [15:0] FC_MCLEAR = 16'h0020;
    localparam logic [15:0] FC_EXECUTE = 16'h0022;
    localparam logic [15:0] FC_STOP_EXEC = 16'h0024;
    localparam logic [15:0] FC_CLR_PARITY = 16'h0025;
    localparam logic [15:0] FC_STEP_ENTER = 16'h0028;
    localparam logic [15:0] FC_STEP_EXIT = 16'h0029;
    localparam logic [15:0] FC_STEP_CLOCK = 16'h002A;
    localparam logic [15:0] FC_STOP_LOAD = 16'h0038;

    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_STATE = 8'h08;
    localparam int unsigned NUM_EVENTS = 4;
    localparam int unsigned EV_PARITY = 0;
    localparam int unsigned EV_CLEAR_DONE = 1;
    localparam int unsigned EV_STOPPED = 2;
    localparam int unsigned EV_BAD_CODE = 3;
    localparam logic [NUM_EVENTS-1:0] MASK_RESET = 4'h0;
endpackage

// ### hfd_pulse.sv
// Purpose: retriggerable-free one-shot of a programmable length
// Assumes: fire is a one-cycle pulse on the same clock
// Notes: a fire while busy is ignored, as a real one-shot would
`timescale 1ns/100ps
module hfd_pulse #(
    parameter int unsigned CW = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [CW-1:0] len,
    output logic busy,
    output logic done
);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy && fire && len != '0) begin
                cnt_q <= len - CW'(1);
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt_q == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - CW'(1);
                end
            end
        end
    end
endmodule

// ### hardware_function_decoder.sv
// Purpose: decode channel function codes into controller control pulses and flags
// Assumes: strobe and code arrive from the processor's pins, asynchronous to ref_clk
// Notes: the code is captured on the strobe's rising edge after synchronising
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
module hardware_function_decoder
    import hfd_pkg::*;
#(
    parameter int unsigned HALT_CYCLES = HALT_CYC,
    parameter int unsigned CLEAR_CYCLES = CLEAR_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic channel_function_strobe,
    input wire logic [15:0] channel_code,
    input wire logic parity_error,
    input wire logic other_error,
    input wire logic director_done,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic load_request,
    output logic exec_enable,
    output logic halt_pulse,
    output logic clear_pulse,
    output logic heads_off,
    output logic clock_inhibit,
    output logic step_pulse,
    output logic composite_status,
    output logic irq
);
    localparam int unsigned CW = 16;

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic strb_m_q, strb_s_q, strb_d_q;
    logic [15:0] code_m_q, code_s_q;
    logic par_m_q, par_s_q, oth_m_q, oth_s_q;

    // code is held stable around the strobe, so bus skew is not a hazard
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strb_m_q <= 1'b0;
            strb_s_q <= 1'b0;
            strb_d_q <= 1'b0;
            code_m_q <= 16'h0000;
            code_s_q <= 16'h0000;
            par_m_q <= 1'b0;
            par_s_q <= 1'b0;
            oth_m_q <= 1'b0;
            oth_s_q <= 1'b0;
        end else begin
            strb_m_q <= channel_function_strobe;
            strb_s_q <= strb_m_q;
            strb_d_q <= strb_s_q;
            code_m_q <= channel_code;
            code_s_q <= code_m_q;
            par_m_q <= parity_error;
            par_s_q <= par_m_q;
            oth_m_q <= other_error;
            oth_s_q <= oth_m_q;
        end
    end

    logic strobe_rise;
    assign strobe_rise = strb_s_q && !strb_d_q;

    // ---------------------------------------------------------------
    // decode enable one-shot
    // ---------------------------------------------------------------
    logic [15:0] code_q;
    logic [CW-1:0] en_cnt_q;
    logic dec_en_q;
    logic is_step_code;
    assign is_step_code = (code_s_q == FC_STEP_ENTER) || (code_s_q == FC_STEP_EXIT)
        || (code_s_q == FC_STEP_CLOCK);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            code_q <= 16'h0000;
            en_cnt_q <= '0;
            dec_en_q <= 1'b0;
        end else if (strobe_rise && !dec_en_q) begin
            code_q <= code_s_q;
            dec_en_q <= 1'b1;
            if (is_step_code) begin
                en_cnt_q <= CW'(DEC_SHORT_CYC - 1);
            end else begin
                en_cnt_q <= CW'(DEC_LONG_CYC - 1);
            end
        end else if (dec_en_q) begin
            if (en_cnt_q == '0) begin
                dec_en_q <= 1'b0;
            end else begin
                en_cnt_q <= en_cnt_q - CW'(1);
            end
        end
    end

    // decode acts once, on the first cycle of the enable window
    logic dec_first_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dec_first_q <= 1'b0;
        end else begin
            dec_first_q <= strobe_rise && !dec_en_q;
        end
    end

    logic do_load, do_mclr, do_exec, do_stop, do_clrpar, do_enter, do_exit, do_step;
    logic do_stopload, bad_code;
    always_comb begin
        do_load = 1'b0;
        do_mclr = 1'b0;
        do_exec = 1'b0;
        do_stop = 1'b0;
        do_clrpar = 1'b0;
        do_enter = 1'b0;
        do_exit = 1'b0;
        do_step = 1'b0;
        do_stopload = 1'b0;
        bad_code = 1'b0;
        if (dec_first_q && dec_en_q) begin
            case (code_q)
                FC_LOAD_BUF: do_load = 1'b1;
                FC_MCLEAR: do_mclr = 1'b1;
                FC_EXECUTE: do_exec = 1'b1;
                FC_STOP_EXEC: do_stop = 1'b1;
                FC_CLR_PARITY: do_clrpar = 1'b1;
                FC_STEP_ENTER: do_enter = 1'b1;
                FC_STEP_EXIT: do_exit = 1'b1;
                FC_STEP_CLOCK: do_step = clock_inhibit;
                FC_STOP_LOAD: do_stopload = 1'b1;
                default: bad_code = 1'b1;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // master clear: halt then clear
    // ---------------------------------------------------------------
    logic halt_busy, halt_done, clr_busy, clr_done;
    hfd_pulse #(.CW(CW)) u_halt (
        .ref_clk(ref_clk),
        .rst(rst),
        .fire(do_mclr),
        .len(CW'(HALT_CYCLES)),
        .busy(halt_busy),
        .done(halt_done)
    );
    hfd_pulse #(.CW(CW)) u_clear (
        .ref_clk(ref_clk),
        .rst(rst),
        .fire(halt_done),
        .len(CW'(CLEAR_CYCLES)),
        .busy(clr_busy),
        .done(clr_done)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            halt_pulse <= 1'b0;
            clear_pulse <= 1'b0;
        end else begin
            halt_pulse <= halt_busy;
            clear_pulse <= clr_busy;
        end
    end

    // ---------------------------------------------------------------
    // director loading and execution
    // ---------------------------------------------------------------
    logic stop_pend_q, par_seen_q;
    always_ff @(posedge ref_clk) begin
        if (rst || clr_busy) begin
            load_request <= 1'b0;
        end else if (do_load) begin
            load_request <= 1'b1;
        end else if (do_stopload) begin
            load_request <= 1'b0;
        end
    end

    // stop does not clear the director address, so execute resumes there
    always_ff @(posedge ref_clk) begin
        if (rst || clr_busy) begin
            exec_enable <= 1'b0;
            stop_pend_q <= 1'b0;
            heads_off <= 1'b0;
        end else begin
            if (par_s_q) begin
                exec_enable <= 1'b0;
                stop_pend_q <= 1'b0;
            end else if (do_exec) begin
                exec_enable <= 1'b1;
                stop_pend_q <= 1'b0;
                heads_off <= 1'b0;
            end else if (do_stop && exec_enable) begin
                stop_pend_q <= 1'b1;
            end else if (stop_pend_q && director_done) begin
                exec_enable <= 1'b0;
                stop_pend_q <= 1'b0;
                heads_off <= 1'b1;
            end else if (do_stop) begin
                heads_off <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // parity error and composite status
    // ---------------------------------------------------------------
    logic par_d_q;
    always_ff @(posedge ref_clk) begin
        if (rst || clr_busy) begin
            par_seen_q <= 1'b0;
            par_d_q <= 1'b0;
            composite_status <= 1'b0;
        end else begin
            par_d_q <= par_s_q;
            if (par_s_q) begin
                par_seen_q <= 1'b1;
            end else if (do_clrpar) begin
                par_seen_q <= 1'b0;
            end
            composite_status <= (par_s_q || (par_seen_q && !do_clrpar)) || oth_s_q;
        end
    end

    // ---------------------------------------------------------------
    // clock step control
    // ---------------------------------------------------------------
    logic [CW-1:0] step_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clock_inhibit <= 1'b0;
        end else if (do_enter) begin
            clock_inhibit <= 1'b1;
        end else if (do_exit) begin
            clock_inhibit <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            step_pulse <= 1'b0;
            step_cnt_q <= '0;
        end else if (do_step) begin
            step_pulse <= 1'b1;
            step_cnt_q <= CW'(STEP_CYC - 1);
        end else if (step_pulse) begin
            if (step_cnt_q == '0) begin
                step_pulse <= 1'b0;
            end else begin
                step_cnt_q <= step_cnt_q - CW'(1);
            end
        end
    end

    // ---------------------------------------------------------------
    // apb slave, interrupt status and mask
    // ---------------------------------------------------------------
    logic [NUM_EVENTS-1:0] ev, status_q, mask_q;
    logic rd_status, wr_mask;
    assign ev[EV_PARITY] = par_s_q && !par_d_q;
    assign ev[EV_CLEAR_DONE] = clr_done;
    assign ev[EV_STOPPED] = stop_pend_q && director_done && !par_s_q && !do_exec;
    assign ev[EV_BAD_CODE] = bad_code;
    assign rd_status = psel && penable && !pwrite && paddr == OFF_STATUS;
    assign wr_mask = psel && penable && pwrite && paddr == OFF_MASK;

    // an event in the clearing read's cycle survives: set wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_q <= '0;
        end else if (rd_status) begin
            status_q <= ev;
        end else begin
            status_q <= status_q | ev;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_q <= MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= pwdata[NUM_EVENTS-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // zero-wait slave: pready high in every access phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == OFF_STATUS) begin
                    prdata <= {28'h0000000, status_q | ev};
                end else if (paddr == OFF_MASK) begin
                    prdata <= {28'h0000000, mask_q};
                end else if (paddr == OFF_STATE) begin
                    prdata <= {24'h000000, heads_off, composite_status, clock_inhibit,
                        stop_pend_q, exec_enable, load_request, clear_pulse, halt_pulse};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_strobe_long;
        strobe_rise && !dec_en_q && !is_step_code;
    endsequence

    AST_LONG_ENABLE: assert property (@(posedge ref_clk) disable iff (rst)
        s_strobe_long |=> dec_en_q [*8] ##33 !dec_en_q)
        else $error("long decode enable length wrong");
    AST_SHORT_ENABLE: assert property (@(posedge ref_clk) disable iff (rst)
        (strobe_rise && !dec_en_q && is_step_code) |=> dec_en_q [*8] ##13 !dec_en_q)
        else $error("short decode enable length wrong");
    AST_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
        (do_load && !clr_busy) |=> load_request)
        else $error("load not started");
    AST_HALT: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(halt_pulse) |-> halt_pulse [*8])
        else $error("halt pulse too short");
    AST_CLEAR_AFTER: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(halt_pulse) |-> ##[0:2] clear_pulse)
        else $error("clear did not follow halt");
    AST_EXEC: assert property (@(posedge ref_clk) disable iff (rst)
        (do_exec && !par_s_q && !clr_busy) |=> exec_enable)
        else $error("execute not started");
    AST_STOP_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        (stop_pend_q && !director_done && !par_s_q && !do_exec && !clr_busy) |=> exec_enable)
        else $error("execution stopped early");
    AST_HEADS: assert property (@(posedge ref_clk) disable iff (rst)
        (stop_pend_q && director_done && !par_s_q && !do_exec && !clr_busy) |=> heads_off)
        else $error("heads not switched off");
    AST_PARITY: assert property (@(posedge ref_clk) disable iff (rst)
        (par_s_q && !clr_busy) |=> !exec_enable)
        else $error("parity did not stop execution");
    AST_STEP_MODE: assert property (@(posedge ref_clk) disable iff (rst)
        do_enter |=> clock_inhibit)
        else $error("step mode not entered");
    AST_STEP_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
        (dec_first_q && dec_en_q && code_q == FC_STEP_CLOCK && !clock_inhibit && !step_pulse)
        |=> !step_pulse)
        else $error("step pulse outside step mode");
    AST_STEP_WIDTH: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(step_pulse) |-> step_pulse [*8] ##13 !step_pulse)
        else $error("step pulse width wrong");
endmodule

// ### proc_model.sv
// Purpose: subsystem processor model that issues function codes
// Assumes: go is a one-cycle request on ref_clk, ignored while busy
// Notes: code is set up 4 cycles before the strobe and held while it is high
`timescale 1ns/100ps
module proc_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [15:0] code_in,
    output logic busy,
    output logic channel_function_strobe,
    output logic [15:0] channel_code
);
    logic [3:0] cnt_q;
    initial begin
        cnt_q = 4'h0;
        busy = 1'b0;
        channel_function_strobe = 1'b0;
        channel_code = 16'hFFFF;
    end
    always @(posedge ref_clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            cnt_q <= 4'h0;
            channel_code <= code_in;
        end else if (busy) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h3) channel_function_strobe <= 1'b1;
            if (cnt_q == 4'h9) channel_function_strobe <= 1'b0;
            if (cnt_q == 4'hA) begin
                // released lines must not keep showing the last code
                channel_code <= ~channel_code;
                busy <= 1'b0;
            end
        end
    end
endmodule

// ### tb_hardware_function_decoder.sv
// Purpose: self-checking bench for the hardware function decoder
// Assumes: halt and clear lengths shortened to 20 and 10 cycles
// Notes: rows run in order, each row sees the state left by the one above
`timescale 1ns/100ps
module tb_hardware_function_decoder;
    import hfd_pkg::*;
    typedef struct packed {logic [15:0] code; logic ld; logic ex; logic ci;} row_s;
    logic ref_clk = 1'b0, rst = 1'b1, go = 1'b0, parity_error = 1'b0, other_error = 1'b0;
    logic director_done = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] code_in = 16'h0000, channel_code;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, load_request, exec_enable, halt_pulse, clear_pulse;
    logic heads_off, clock_inhibit, step_pulse, composite_status, irq, busy, strobe, seen;
    int mismatches = 0, checks = 0, w;
    row_s rows[7] = '{'{FC_LOAD_BUF, 1, 0, 0}, '{FC_STOP_LOAD, 0, 0, 0},
        '{FC_LOAD_BUF, 1, 0, 0}, '{FC_EXECUTE, 1, 1, 0}, '{FC_STEP_ENTER, 1, 1, 1},
        '{FC_STEP_EXIT, 1, 1, 0}, '{16'h0055, 1, 1, 0}};
    always #2.5 ref_clk = ~ref_clk;
    proc_model i_proc_model (.ref_clk(ref_clk), .go(go), .code_in(code_in), .busy(busy),
        .channel_function_strobe(strobe), .channel_code(channel_code));
    hardware_function_decoder #(.HALT_CYCLES(20), .CLEAR_CYCLES(10)) i_hardware_function_decoder (
        .ref_clk(ref_clk), .rst(rst), .channel_function_strobe(strobe),
        .channel_code(channel_code), .parity_error(parity_error), .other_error(other_error),
        .director_done(director_done), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .load_request(load_request), .exec_enable(exec_enable), .halt_pulse(halt_pulse),
        .clear_pulse(clear_pulse), .heads_off(heads_off), .clock_inhibit(clock_inhibit),
        .step_pulse(step_pulse), .composite_status(composite_status), .irq(irq));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task end_sim;
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task timeout;
        mismatches++;
        $display("wrong value at %0t: wait ran out", $time);
        end_sim;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) timeout;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task issue(input logic [15:0] c, input int gap);
        @(posedge ref_clk);
        go <= 1'b1;
        code_in <= c;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (gap) @(posedge ref_clk);
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: pick = halt_pulse;
            1: pick = clear_pulse;
            default: pick = step_pulse;
        endcase
    endfunction
    task pulse_len(input int k);
        int n;
        n = 0;
        w = 0;
        while (pick(k) !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 200) timeout;
        while (pick(k) === 1'b1 && w < 200) begin
            @(posedge ref_clk);
            w++;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({load_request, exec_enable, clock_inhibit, halt_pulse, irq}, 0);
        apb(1'b0, OFF_MASK, 0);
        chk(rd, MASK_RESET);
        foreach (rows[i]) begin
            issue(rows[i].code, 50);
            chk({load_request, exec_enable, clock_inhibit}, rows[i][2:0]);
        end
        chk(irq, 0);
        apb(1'b1, OFF_MASK, 32'h8);
        apb(1'b0, OFF_MASK, 0);
        chk(rd, 32'h8);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1);
        apb(1'b0, OFF_STATUS, 0);
        chk(rd, 32'h8);
        repeat (3) @(posedge ref_clk);
        chk(irq, 0);
        apb(1'b0, OFF_STATE, 0);
        chk(rd, 32'h0C);
        apb(1'b0, 8'h10, 0);
        chk({err, rd}, {1'b1, 32'h0});
        // a strobe inside the long enable window is dropped
        issue(16'h0055, 25);
        issue(FC_STOP_LOAD, 50);
        chk(load_request, 1);
        // the short window of step codes lets the next strobe through
        issue(FC_STEP_ENTER, 25);
        issue(FC_STEP_CLOCK, 1);
        pulse_len(2);
        chk(w, 20);
        issue(FC_STEP_EXIT, 50);
        issue(FC_STEP_CLOCK, 1);
        seen = 1'b0;
        repeat (50) @(posedge ref_clk) if (step_pulse !== 1'b0) seen = 1'b1;
        chk(seen, 0);
        issue(FC_STOP_EXEC, 50);
        chk({exec_enable, heads_off}, 2'b10);
        director_done <= 1'b1;
        @(posedge ref_clk);
        director_done <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk({exec_enable, heads_off}, 2'b01);
        issue(FC_EXECUTE, 50);
        chk({exec_enable, halt_pulse, load_request}, 3'b101);
        parity_error <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk({exec_enable, composite_status}, 2'b01);
        parity_error <= 1'b0;
        other_error <= 1'b1;
        issue(FC_CLR_PARITY, 50);
        chk(composite_status, 1);
        other_error <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk(composite_status, 0);
        issue(FC_EXECUTE, 50);
        chk(exec_enable, 1);
        issue(FC_MCLEAR, 1);
        pulse_len(0);
        chk(w, 20);
        pulse_len(1);
        chk(w, 10);
        chk({load_request, exec_enable}, 2'b00);
        end_sim;
    end
endmodule
